// ===== logic/spch_pkg.sv
package spch_pkg;
   // clock and timing
   localparam int CLK_HZ = 10_000_000;
   localparam int CLK_PERIOD_NS = 100;
   localparam int MS_NS = 1_000_000;
   localparam int CYC_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // configuration register word addresses
   localparam logic [15:0] OFS_PORT_ENABLE = 16'h1194;
   localparam logic [15:0] OFS_LINE_RATE = 16'h1195;
   localparam logic [15:0] OFS_PARITY_SELECT = 16'h1196;
   localparam logic [15:0] OFS_CHAR_LENGTH = 16'h1197;
   localparam logic [15:0] OFS_STOP_BIT_COUNT = 16'h1198;
   localparam logic [15:0] OFS_RTS_ON_DELAY = 16'h119A;
   localparam logic [15:0] OFS_RTS_OFF_DELAY = 16'h119B;
   localparam logic [15:0] OFS_CTS_ENABLE = 16'h119C;

   // reset values
   localparam logic [15:0] RST_PORT_ENABLE = 16'h0000;
   localparam logic [15:0] RST_LINE_RATE = 16'h2580;
   localparam logic [15:0] RST_PARITY_SELECT = 16'h0000;
   localparam logic [15:0] RST_CHAR_LENGTH = 16'h0008;
   localparam logic [15:0] RST_STOP_BIT_COUNT = 16'h0001;
   localparam logic [15:0] RST_RTS_DELAY = 16'h0000;
   localparam logic [15:0] RST_CTS_ENABLE = 16'h0000;

   // field codes
   localparam logic [15:0] PORT_ON_CODE = 16'h0001;
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ODD = 2'h1;
   localparam logic [1:0] PAR_EVEN = 2'h2;
   localparam logic [15:0] TWO_STOP_CODE = 16'h0002;
   localparam logic [3:0] BITS_MIN = 4'h5;
   localparam logic [3:0] BITS_MAX = 4'h8;

   // decoded active configuration
   typedef struct packed {
      logic en;
      logic [15:0] div;
      logic [1:0] par;
      logic [3:0] bits;
      logic two_stop;
      logic [15:0] on_ms;
      logic [15:0] off_ms;
      logic cts_en;
   } spch_cfg_type;

   // clock cycles per bit for a literal rate value, 115 meaning 115200
   function automatic logic [15:0] spch_bit_div(input logic [15:0] rate);
      case (rate)
         16'd300: spch_bit_div = 16'(CLK_HZ / 300);
         16'd600: spch_bit_div = 16'(CLK_HZ / 600);
         16'd1200: spch_bit_div = 16'(CLK_HZ / 1200);
         16'd2400: spch_bit_div = 16'(CLK_HZ / 2400);
         16'd4800: spch_bit_div = 16'(CLK_HZ / 4800);
         16'd19200: spch_bit_div = 16'(CLK_HZ / 19200);
         16'd38400: spch_bit_div = 16'(CLK_HZ / 38400);
         16'd57600: spch_bit_div = 16'(CLK_HZ / 57600);
         16'd115: spch_bit_div = 16'(CLK_HZ / 115200);
         default: spch_bit_div = 16'(CLK_HZ / 9600);
      endcase
   endfunction

   // parity over the configured data bits only
   function automatic logic spch_parity(input logic [7:0] data, input logic [3:0] bits,
                                        input logic [1:0] par);
      logic [7:0] mask;
      mask = 8'hFF >> (4'h8 - bits);
      spch_parity = (^(data & mask)) ^ (par == PAR_ODD);
   endfunction
endpackage

// ===== logic/spch_rx.sv
`timescale 1ns/1ps
module spch_rx
   import spch_pkg::*;
(
   input wire logic clk_sys, // system clock
   input wire logic reset, // synchronous reset
   input spch_pkg::spch_cfg_type cfg, // active configuration
   input wire logic port_on, // port operating
   input wire logic rxd, // serial receive line
   output logic rx_valid, // one-cycle character strobe
   output logic [7:0] rx_data, // received character
   output logic rx_parity_err, // parity mismatch with rx_valid
   output logic rx_frame_err // missing stop bit with rx_valid
);
   import spch_pkg::*;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b000,
      RX_START = 3'b001,
      RX_DATA = 3'b010,
      RX_PAR = 3'b011,
      RX_STOP = 3'b100
   } spch_rx_state_type;

   spch_rx_state_type state;
   logic [15:0] tmr;
   logic [3:0] idx;
   logic [7:0] shreg;
   logic par_bad;

   ////////////////////////////////////////////////////////////////////////
   // receive sequencer, each bit sampled at its middle
   always_ff @(posedge clk_sys) begin
      rx_valid <= 1'b0;
      if (reset || !port_on) begin // R1
         state <= RX_IDLE;
         tmr <= 16'h0000;
         idx <= 4'h0;
         shreg <= 8'h00;
         par_bad <= 1'b0;
         rx_data <= 8'h00;
         rx_parity_err <= 1'b0;
         rx_frame_err <= 1'b0;
      end else if (state == RX_IDLE) begin
         if (!rxd) begin
            state <= RX_START;
            tmr <= cfg.div >> 1;
         end
      end else if (tmr != 16'h0000) begin
         tmr <= tmr - 16'h0001;
      end else begin
         tmr <= cfg.div - 16'h0001;
         case (state)
            RX_START: begin
               idx <= 4'h0;
               shreg <= 8'h00;
               state <= rxd ? RX_IDLE : RX_DATA;
            end
            RX_DATA: begin
               shreg[idx[2:0]] <= rxd; // R4
               idx <= idx + 4'h1;
               if (idx == cfg.bits - 4'h1) begin
                  state <= (cfg.par == PAR_NONE) ? RX_STOP : RX_PAR; // R3
               end
            end
            RX_PAR: begin
               par_bad <= rxd != spch_parity(shreg, cfg.bits, cfg.par); // R12
               state <= RX_STOP;
            end
            RX_STOP: begin
               rx_valid <= 1'b1;
               rx_data <= shreg;
               rx_parity_err <= (cfg.par != PAR_NONE) && par_bad;
               rx_frame_err <= !rxd;
               par_bad <= 1'b0;
               state <= RX_IDLE;
            end
            default: state <= RX_IDLE;
         endcase
      end
   end

   a_rx_port_off: assert property (@(posedge clk_sys) disable iff (reset) // R1
      !port_on |=> !rx_valid) else $error("character strobed while port off");
   a_rx_data_bits: assert property (@(posedge clk_sys) disable iff (reset) // R4
      state == RX_DATA |-> idx < cfg.bits) else $error("too many data bits received");

endmodule // spch_rx

// ===== logic/spch_port.sv
`timescale 1ns/1ps
// How it works
// R1: port runs only when enable holds one; otherwise idle and quiet.
// R2: line rate is a literal bit-per-second value, 115 means the highest rate.
// R3: characters carry no parity, odd parity or even parity as selected.
// R4: five to eight data bits per character.
// R5: one or two stop bits after every sent character.
// R6: request-to-send and clear-to-send handshaking is optional.
// R7: without a far-side handshake, wiring loops request-to-send back to clear-to-send.
// R8: settings are loaded from the host at initialisation before serial operation.
// R9: after raising request-to-send, wait the configured milliseconds before sending.
// R10: after the last byte, hold request-to-send the configured milliseconds, then drop.
// R11: clear-to-send ignored when gating is off; otherwise send only while high.
// R12: parity covers configured data bits only, follows last data bit, checked on receive.
module spch_port
   import spch_pkg::*;
#(
   parameter int CYC_PER_MS_P = CYC_PER_MS // cycles per millisecond
) (
   input wire logic clk_sys, // system clock
   input wire logic reset, // synchronous reset
   input wire logic cfg_wr, // configuration write strobe
   input wire logic [15:0] cfg_addr, // configuration word address
   input wire logic [15:0] cfg_wdata, // configuration write data
   output logic [15:0] cfg_rdata, // readback of cfg_addr, one cycle later
   input wire logic cfg_init, // initialise: make settings active
   output logic port_active, // port loaded and enabled
   input wire logic tx_valid, // character offered
   input wire logic [7:0] tx_data, // character to send
   output logic tx_ready, // character taken this cycle
   output logic rx_valid, // character received strobe
   output logic [7:0] rx_data, // received character
   output logic rx_parity_err, // received parity error
   output logic rx_frame_err, // received framing error
   output logic txd, // serial transmit line
   input wire logic rxd, // serial receive line
   output logic rts, // request to send, high active
   input wire logic cts // clear to send, high active
);
   import spch_pkg::*;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_LEAD = 3'b001,
      TX_CTS = 3'b010,
      TX_START = 3'b011,
      TX_DATA = 3'b100,
      TX_PAR = 3'b101,
      TX_STOP = 3'b110,
      TX_TAIL = 3'b111
   } spch_tx_state_type;

   logic [15:0] port_enable;
   logic [15:0] line_rate;
   logic [15:0] parity_select;
   logic [15:0] char_length;
   logic [15:0] stop_bit_count;
   logic [15:0] rts_on_delay;
   logic [15:0] rts_off_delay;
   logic [15:0] cts_enable;
   spch_cfg_type act;
   logic loaded;
   logic port_on;
   spch_tx_state_type state, next_state;
   logic [31:0] ms_cyc;
   logic [15:0] ms_cnt;
   logic [15:0] bit_tmr;
   logic bit_done;
   logic [3:0] bit_idx;
   logic [7:0] tx_char;
   logic [7:0] shreg, next_shreg;
   logic cts_ok;

   ////////////////////////////////////////////////////////////////////////
   // configuration registers written by the host
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         port_enable <= RST_PORT_ENABLE;
         line_rate <= RST_LINE_RATE;
         parity_select <= RST_PARITY_SELECT;
         char_length <= RST_CHAR_LENGTH;
         stop_bit_count <= RST_STOP_BIT_COUNT;
         rts_on_delay <= RST_RTS_DELAY;
         rts_off_delay <= RST_RTS_DELAY;
         cts_enable <= RST_CTS_ENABLE;
      end else if (cfg_wr) begin
         case (cfg_addr)
            OFS_PORT_ENABLE: port_enable <= cfg_wdata;
            OFS_LINE_RATE: line_rate <= cfg_wdata;
            OFS_PARITY_SELECT: parity_select <= cfg_wdata;
            OFS_CHAR_LENGTH: char_length <= cfg_wdata;
            OFS_STOP_BIT_COUNT: stop_bit_count <= cfg_wdata;
            OFS_RTS_ON_DELAY: rts_on_delay <= cfg_wdata;
            OFS_RTS_OFF_DELAY: rts_off_delay <= cfg_wdata;
            OFS_CTS_ENABLE: cts_enable <= cfg_wdata;
            default: ;
         endcase
      end
   end

   // readback, unmapped addresses read zero
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cfg_rdata <= 16'h0000;
      end else begin
         case (cfg_addr)
            OFS_PORT_ENABLE: cfg_rdata <= port_enable;
            OFS_LINE_RATE: cfg_rdata <= line_rate;
            OFS_PARITY_SELECT: cfg_rdata <= parity_select;
            OFS_CHAR_LENGTH: cfg_rdata <= char_length;
            OFS_STOP_BIT_COUNT: cfg_rdata <= stop_bit_count;
            OFS_RTS_ON_DELAY: cfg_rdata <= rts_on_delay;
            OFS_RTS_OFF_DELAY: cfg_rdata <= rts_off_delay;
            OFS_CTS_ENABLE: cfg_rdata <= cts_enable;
            default: cfg_rdata <= 16'h0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // active settings taken only at initialisation
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         act <= '0;
         loaded <= 1'b0;
      end else if (cfg_init) begin // R8
         loaded <= 1'b1;
         act.en <= port_enable == PORT_ON_CODE; // R1
         act.div <= spch_bit_div(line_rate); // R2
         act.par <= (parity_select[1:0] == PAR_ODD || parity_select[1:0] == PAR_EVEN) ?
                    parity_select[1:0] : PAR_NONE; // R3
         act.bits <= (char_length < 16'(BITS_MIN) || char_length > 16'(BITS_MAX)) ?
                     BITS_MAX : char_length[3:0]; // R4
         act.two_stop <= stop_bit_count == TWO_STOP_CODE; // R5
         act.on_ms <= rts_on_delay;
         act.off_ms <= rts_off_delay;
         act.cts_en <= cts_enable != 16'h0000; // R6
      end
   end

   assign port_on = loaded && act.en; // R1
   assign port_active = port_on;
   assign cts_ok = !act.cts_en || cts; // R11
   assign tx_ready = port_on && state == TX_CTS && cts_ok; // R11
   assign bit_done = bit_tmr == 16'h0000;

   ////////////////////////////////////////////////////////////////////////
   // transmit sequencer
   always_comb begin
      next_state = state;
      case (state)
         TX_IDLE: if (tx_valid) next_state = TX_LEAD;
         TX_LEAD: if (ms_cnt == act.on_ms) next_state = TX_CTS; // R9
         TX_CTS: begin
            if (tx_valid && cts_ok) next_state = TX_START; // R11
            else if (!tx_valid) next_state = TX_TAIL;
         end
         TX_START: if (bit_done) next_state = TX_DATA;
         TX_DATA: begin
            if (bit_done && bit_idx == act.bits - 4'h1) begin // R4
               next_state = (act.par == PAR_NONE) ? TX_STOP : TX_PAR; // R12
            end
         end
         TX_PAR: if (bit_done) next_state = TX_STOP;
         TX_STOP: begin
            if (bit_done && (!act.two_stop || bit_idx == 4'h1)) next_state = TX_TAIL; // R5
         end
         TX_TAIL: begin
            if (tx_valid) next_state = TX_CTS;
            else if (ms_cnt == act.off_ms) next_state = TX_IDLE; // R10
         end
         default: next_state = TX_IDLE;
      endcase
      if (!port_on) next_state = TX_IDLE; // R1
   end

   always_ff @(posedge clk_sys) begin
      if (reset) state <= TX_IDLE;
      else state <= next_state;
   end

   // millisecond timer, restarted on every state change
   always_ff @(posedge clk_sys) begin
      if (reset || next_state != state) begin
         ms_cyc <= 32'h00000000;
         ms_cnt <= 16'h0000;
      end else if (ms_cyc == 32'(CYC_PER_MS_P - 1)) begin
         ms_cyc <= 32'h00000000;
         if (ms_cnt != 16'hFFFF) ms_cnt <= ms_cnt + 16'h0001;
      end else begin
         ms_cyc <= ms_cyc + 32'h00000001;
      end
   end

   // bit timer and bit index
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         bit_tmr <= 16'h0000;
         bit_idx <= 4'h0;
      end else if (next_state != state) begin
         bit_tmr <= act.div - 16'h0001; // R2
         bit_idx <= 4'h0;
      end else if (state == TX_IDLE) begin
         bit_tmr <= 16'h0000; // parked, so a newly loaded rate never meets a stale count
         bit_idx <= 4'h0;
      end else if (bit_done) begin
         bit_tmr <= act.div - 16'h0001;
         bit_idx <= bit_idx + 4'h1;
      end else begin
         bit_tmr <= bit_tmr - 16'h0001;
      end
   end

   // character shift register, lsb first
   always_comb begin
      next_shreg = shreg;
      if (tx_ready && tx_valid) next_shreg = tx_data;
      else if (state == TX_DATA && bit_done) next_shreg = {1'b0, shreg[7:1]};
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         shreg <= 8'h00;
         tx_char <= 8'h00;
      end else begin
         shreg <= next_shreg;
         if (tx_ready && tx_valid) tx_char <= tx_data;
      end
   end

   // line and request-to-send drivers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         txd <= 1'b1;
         rts <= 1'b0;
      end else begin
         rts <= next_state != TX_IDLE; // R9 R10
         case (next_state)
            TX_START: txd <= 1'b0;
            TX_DATA: txd <= next_shreg[0]; // R4
            TX_PAR: txd <= spch_parity(tx_char, act.bits, act.par); // R12
            default: txd <= 1'b1; // R5
         endcase
      end
   end

   spch_rx spch_rx_i (
      .clk_sys(clk_sys),
      .reset(reset),
      .cfg(act),
      .port_on(port_on),
      .rxd(rxd),
      .rx_valid(rx_valid),
      .rx_data(rx_data),
      .rx_parity_err(rx_parity_err),
      .rx_frame_err(rx_frame_err)
   );

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_port_off_quiet: assert property (@(posedge clk_sys) disable iff (reset) // R1
      !port_on |=> txd && !rts) else $error("port off but line active");
   a_rate_divider: assert property (@(posedge clk_sys) disable iff (reset) // R2
      port_on |-> bit_tmr < act.div) else $error("bit timer beyond rate divisor");
   a_parity_bit: assert property (@(posedge clk_sys) disable iff (reset) // R12
      state == TX_PAR |-> act.par != PAR_NONE && txd == spch_parity(tx_char, act.bits,
      act.par)) else $error("wrong parity bit");
   a_data_count: assert property (@(posedge clk_sys) disable iff (reset) // R4
      state == TX_DATA |-> bit_idx < act.bits) else $error("too many data bits sent");
   a_stop_level: assert property (@(posedge clk_sys) disable iff (reset) // R5
      state == TX_STOP |-> txd && rts) else $error("stop bit not high");
   a_cfg_stable: assert property (@(posedge clk_sys) disable iff (reset) // R8
      !cfg_init |=> $stable(act)) else $error("settings changed without init");
   a_rts_lead: assert property (@(posedge clk_sys) disable iff (reset) // R9
      state == TX_LEAD && next_state == TX_CTS |-> rts && ms_cnt >= act.on_ms)
      else $error("sent before lead delay");
   a_rts_release: assert property (@(posedge clk_sys) disable iff (reset) // R10
      $fell(rts) && $past(port_on) |-> $past(state) == TX_TAIL)
      else $error("request-to-send dropped outside tail");
   a_cts_gate: assert property (@(posedge clk_sys) disable iff (reset) // R11
      tx_ready |-> cts || !act.cts_en) else $error("sent without clear-to-send");

endmodule // spch_port

// ===== dv/spch_modem.sv
`timescale 1ns/1ps
// far-side serial device: decodes txd, sends frames on rxd
module spch_modem (
   input wire logic clk_sys, // system clock
   input wire logic txd, // line from the port
   input wire logic rts, // request to send
   input wire logic cts_hold, // hold clear-to-send low
   input wire logic [15:0] div, // cycles per bit
   input wire logic [3:0] bits, // data bits
   input wire logic par_on, // parity bit present
   input wire logic two_stop, // second stop bit
   output logic rxd, // line to the port
   output logic cts // clear to send
);
   int cyc = 0;
   int last = 0;
   int span = 0;
   int cnt = 0;
   logic [7:0] data = 8'h00;
   logic pbit = 1'b0;
   logic stop_ok = 1'b0;
   initial rxd = 1'b1;
   // without own handshake the wiring loops rts back to cts
   assign cts = rts & ~cts_hold;
   always @(posedge clk_sys) cyc <= cyc + 1;
   // decode each character at mid-bit, span is start to start
   always begin
      @(negedge txd);
      span = cyc - last;
      last = cyc;
      repeat (div / 2) @(posedge clk_sys);
      data = 8'h00;
      for (int i = 0; i < bits; i++) begin
         repeat (div) @(posedge clk_sys);
         data[i] = txd;
      end
      if (par_on) begin
         repeat (div) @(posedge clk_sys);
         pbit = txd;
      end
      repeat (div) @(posedge clk_sys);
      stop_ok = txd;
      cnt++;
   end
   // send one frame, line idles at mark
   task automatic send(input logic [7:0] d, input logic p);
      @(negedge clk_sys);
      rxd = 1'b0;
      repeat (div) @(negedge clk_sys);
      for (int i = 0; i < bits; i++) begin
         rxd = d[i];
         repeat (div) @(negedge clk_sys);
      end
      if (par_on) begin
         rxd = p;
         repeat (div) @(negedge clk_sys);
      end
      rxd = 1'b1;
      repeat (two_stop ? 2 * div : div) @(negedge clk_sys);
   endtask
endmodule // spch_modem

// ===== dv/spch_port_tb.sv
`timescale 1ns/1ps
module spch_port_tb;
   import spch_pkg::*;
   localparam int MS = 10; // shortened millisecond
   logic clk_sys = 1'b0, reset = 1'b1, cfg_wr = 1'b0, cfg_init = 1'b0, tx_valid = 1'b0;
   logic [15:0] cfg_addr = 16'h0000, cfg_wdata = 16'h0000, cfg_rdata;
   logic [7:0] tx_data = 8'h00, rx_data;
   logic port_active, tx_ready, rx_valid, rx_parity_err, rx_frame_err, txd, rxd, rts, cts;
   logic cts_hold = 1'b0, par_on = 1'b0, two_stop = 1'b0, bad;
   logic [15:0] div = 16'h0056, on_ms = 16'h0000, off_ms = 16'h0000;
   logic [3:0] bits = 4'h8;
   logic [1:0] par = 2'h0;
   int error_cnt = 0, check_count = 0, rx_seen = 0, n, c;
   logic [15:0] rates [3] = '{16'd115, 16'd57600, 16'd38400};
   logic [15:0] ra [9] = '{OFS_PORT_ENABLE, OFS_LINE_RATE, OFS_PARITY_SELECT, OFS_CHAR_LENGTH,
      OFS_STOP_BIT_COUNT, OFS_RTS_ON_DELAY, OFS_RTS_OFF_DELAY, OFS_CTS_ENABLE, 16'h1199};
   logic [15:0] rv [9] = '{RST_PORT_ENABLE, RST_LINE_RATE, RST_PARITY_SELECT, RST_CHAR_LENGTH,
      RST_STOP_BIT_COUNT, RST_RTS_DELAY, RST_RTS_DELAY, RST_CTS_ENABLE, 16'h0000};
   always #50 clk_sys = ~clk_sys;
   // count receive strobes
   always @(posedge clk_sys) if (rx_valid === 1'b1) rx_seen <= rx_seen + 1;
   spch_port #(.CYC_PER_MS_P(MS)) spch_port_i (.clk_sys(clk_sys), .reset(reset),
      .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .cfg_init(cfg_init), .port_active(port_active), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_parity_err(rx_parity_err), .rx_frame_err(rx_frame_err), .txd(txd), .rxd(rxd),
      .rts(rts), .cts(cts));
   spch_modem spch_modem_i (.clk_sys(clk_sys), .txd(txd), .rts(rts), .cts_hold(cts_hold),
      .div(div), .bits(bits), .par_on(par_on), .two_stop(two_stop), .rxd(rxd), .cts(cts));
   ////////////////////////////////////////////////////////////
   // expected cycles per bit, parity bit and data mask
   function automatic logic [15:0] bit_div(input logic [15:0] r);
      return (r == 16'd115) ? 16'd86 : 16'(CLK_HZ / r);
   endfunction
   function automatic logic [7:0] mask();
      return 8'hFF >> (8 - bits);
   endfunction
   function automatic logic exp_par(input logic [7:0] d);
      return (^(d & mask())) ^ (par == PAR_ODD);
   endfunction
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // configuration bus: write strobe held across back-to-back writes
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge clk_sys);
      cfg_wr = 1'b1;
      cfg_addr = a;
      cfg_wdata = d;
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      @(negedge clk_sys);
      cfg_wr = 1'b0;
      cfg_addr = a;
      @(negedge clk_sys);
      check("cfg_rdata", cfg_rdata, exp);
   endtask
   task automatic setup(input logic [15:0] en, rate, input logic [1:0] p, input logic [3:0] b,
                        input logic two, input logic [15:0] on, off, ce);
      wr(OFS_PORT_ENABLE, en);
      wr(OFS_LINE_RATE, rate);
      wr(OFS_PARITY_SELECT, 16'(p));
      wr(OFS_CHAR_LENGTH, 16'(b));
      wr(OFS_STOP_BIT_COUNT, two ? TWO_STOP_CODE : 16'h0001);
      wr(OFS_RTS_ON_DELAY, on);
      wr(OFS_RTS_OFF_DELAY, off);
      wr(OFS_CTS_ENABLE, ce);
      @(negedge clk_sys);
      cfg_wr = 1'b0;
      cfg_init = 1'b1;
      @(negedge clk_sys);
      cfg_init = 1'b0;
      div = bit_div(rate);
      par = p;
      bits = b;
      par_on = (p == PAR_ODD || p == PAR_EVEN);
      two_stop = two;
      on_ms = on;
      off_ms = off;
      @(negedge clk_sys);
      check("port_active", 16'(port_active), 16'(en == PORT_ON_CODE));
   endtask
   task automatic wait_ready();
      n = 0;
      while (tx_ready !== 1'b1 && n < 8000) begin
         @(negedge clk_sys);
         n++;
      end
   endtask
   task automatic wait_rx(input int c0);
      n = 0;
      while (spch_modem_i.cnt < c0 && n < 9000) begin
         @(negedge clk_sys);
         n++;
      end
      check("tx_data", 16'(spch_modem_i.data), 16'(tx_data & mask()));
      if (par_on) check("tx_parity", 16'(spch_modem_i.pbit), 16'(exp_par(tx_data)));
      check("tx_stop", 16'(spch_modem_i.stop_ok), 16'h0001);
   endtask
   // two characters back to back with lead, span and tail timing
   task automatic send_pair(input logic [7:0] d0, d1);
      c = spch_modem_i.cnt;
      @(negedge clk_sys);
      tx_valid = 1'b1;
      tx_data = d0;
      n = 0;
      while (rts !== 1'b1 && n < 50) begin
         @(negedge clk_sys);
         n++;
      end
      n = 0;
      while (txd !== 1'b0 && n < 2000) begin
         @(negedge clk_sys);
         n++;
      end
      check("rts_lead", 16'(n >= on_ms * MS && n <= on_ms * MS + 4), 16'h0001);
      tx_data = d1;
      wait_ready();
      @(negedge clk_sys);
      tx_valid = 1'b0;
      wait_rx(c + 2);
      n = div * (2 + bits + par_on + two_stop);
      c = spch_modem_i.span;
      check("tx_span", 16'(c >= n && c <= n + 4), 16'h0001);
      n = 0;
      while (rts !== 1'b0 && n < 3000) begin
         @(negedge clk_sys);
         n++;
      end
      c = off_ms * MS + div / 2;
      check("rts_tail", 16'(n >= c - 2 && n <= c + two_stop * div + 8), 16'h0001);
   endtask
   task automatic rx_check(input logic [7:0] d, input logic flip);
      c = rx_seen;
      spch_modem_i.send(d, exp_par(d) ^ flip);
      check("rx_count", 16'(rx_seen), 16'(c + 1));
      check("rx_data", 16'(rx_data), 16'(d & mask()));
      if (par_on) check("rx_parity_err", 16'(rx_parity_err), 16'(flip));
      check("rx_frame_err", 16'(rx_frame_err), 16'h0000);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (98000) @(posedge clk_sys);
      error_cnt++;
      complete_run();
   end
   initial begin
      void'($urandom(11));
      repeat (20) @(posedge clk_sys);
      @(negedge clk_sys);
      reset = 1'b0;
      for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
      wr(OFS_PORT_ENABLE, PORT_ON_CODE);
      rd(OFS_PORT_ENABLE, PORT_ON_CODE);
      check("port_active", 16'(port_active), 16'h0000);
      $display("test registers done");
      // port off: line quiet, nothing received
      setup(16'h0000, 16'd115, PAR_NONE, 4'h8, 1'b0, 16'h0000, 16'h0000, 16'h0000);
      tx_valid = 1'b1;
      bad = 1'b0;
      repeat (200) begin
         @(negedge clk_sys);
         bad = bad | (rts !== 1'b0) | (txd !== 1'b1);
      end
      tx_valid = 1'b0;
      check("quiet_line", 16'(bad), 16'h0000);
      c = rx_seen;
      spch_modem_i.send(8'($urandom), 1'b0);
      check("rx_off", 16'(rx_seen), 16'(c));
      $display("test disabled done");
      for (int k = 0; k < 6; k++) begin
         setup(16'h0001, rates[$urandom % 3], 2'(k % 3), 4'(5 + k % 4), 1'(k % 2),
               16'h0000, 16'h0000, 16'h0000);
         send_pair(8'($urandom), 8'($urandom));
         rx_check(8'($urandom), 1'b0);
         rx_check(8'($urandom), par_on);
      end
      $display("test framing done");
      setup(16'h0001, 16'd115, PAR_EVEN, 4'h7, 1'b0, 16'h0002, 16'h0003, 16'h0000);
      send_pair(8'hA5, 8'h3C);
      $display("test rts delays done");
      // gating on with cts low holds the character back
      setup(16'h0001, 16'd115, PAR_NONE, 4'h8, 1'b0, 16'h0000, 16'h0000, 16'h0001);
      cts_hold = 1'b1;
      c = spch_modem_i.cnt;
      tx_data = 8'($urandom);
      tx_valid = 1'b1;
      bad = 1'b0;
      repeat (100) begin
         @(negedge clk_sys);
         bad = bad | (tx_ready !== 1'b0) | (txd !== 1'b1);
      end
      check("cts_block", 16'(bad), 16'h0000);
      cts_hold = 1'b0;
      wait_ready();
      @(negedge clk_sys);
      tx_valid = 1'b0;
      wait_rx(c + 1);
      // let the stop bit and tail finish before new settings are loaded
      n = 0;
      while (rts !== 1'b0 && n < 3000) begin
         @(negedge clk_sys);
         n++;
      end
      check("rts_idle", 16'(rts), 16'h0000);
      // gating off ignores a low cts
      setup(16'h0001, 16'd57600, PAR_ODD, 4'h6, 1'b1, 16'h0000, 16'h0001, 16'h0000);
      cts_hold = 1'b1;
      send_pair(8'($urandom), 8'($urandom));
      $display("test handshake done");
      complete_run();
   end
endmodule // spch_port_tb
